// file: hdl/bit_sync.sv
// Two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ns
module bit_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } sync_st_t;

  sync_st_t s_r;
  sync_st_t s_nxt;

  always_comb
  begin
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign q = s_r.s2;

endmodule // bit_sync

// file: hdl/two_wire_master.sv
// Two-wire bus master with sub-address, core side and link side
`timescale 1ns/1ns
//
// Contract
// R1 - Every byte on the data line is exactly eight bits.
// R2 - Bytes are shifted out most significant bit first.
// R3 - Receiver answers each byte with an acknowledge in the ninth clock slot.
// R4 - No upper limit on data bytes between start and stop.
// R5 - Every transfer opens with a start and closes with a stop.
// R6 - Start: data falls while clock line is high.
// R7 - Stop: data rises while clock line is high.
// R8 - Two directions: master transmitter and master receiver.
// R9 - Single or sequential transfers, each with or without sub-address.
// R10 - Sub-address bytes follow slave address and precede data.
// R11 - Read with sub-address writes the sub-address first, then reads.
// R12 - Repeated start, no stop, between sub-address write and read.
// R13 - Software programs low, high and common clock dividers before use.
// R14 - Software sets master enable before starting any transfer.
// R15 - Software loads slave address, sub-address count and direction; one means read.
// R16 - Single-byte read: start and stop given together.
// R17 - Receive-ready flag set while a received byte waits.
// R18 - Transfer-complete flag set once transfer including stop has finished.
// R19 - Slave pointer takes the configured sub-address value.
// R20 - Sensor answers fixed upper nibble plus three strap bits.
// R21 - Sensor pointer is eight bits, two low bits select register.
// R22 - Sensor temperature is sixteen bits, read as two bytes.
// R23 - Receiver acknowledges all bytes but the last, which gets not-acknowledge.
// R24 - Repeated start only occurs in receive operation.
// R25 - Master waits while a slave holds the clock line low.
module two_wire_master
  import two_wire_master_pkg::*;
(
  // Core clock and reset
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  // Link clock
  input  wire logic              link_clk,
  // Commands
  input  wire logic              master_enable_cmd,
  input  wire logic              start_cmd,
  input  wire logic              stop_cmd,
  // Mode and sub-address
  input  wire logic [ADDR_W-1:0] slave_address,
  input  wire logic [SUBN_W-1:0] subaddress_byte_count,
  input  wire logic              read_direction_bit,
  input  wire logic [SUB_W-1:0]  slave_subaddress_value,
  input  wire logic [NB_W-1:0]   data_byte_count,
  // Clock waveform
  input  wire logic [DIV_W-1:0]  low_period_divider,
  input  wire logic [DIV_W-1:0]  high_period_divider,
  input  wire logic [CK_W-1:0]   common_clock_divider,
  // Transmit holding
  input  wire logic [7:0]        tx_data,
  input  wire logic              tx_load,
  output logic                   tx_empty_flag,
  // Receive holding
  input  wire logic              rx_read,
  output logic [7:0]             rx_data,
  output logic                   receive_ready_flag,
  // Status
  output logic                   transfer_complete_flag,
  output logic                   nack_flag,
  output logic                   busy_flag,
  // Open-drain bus pins
  input  wire logic              serial_clock_line_in,
  output logic                   serial_clock_line_out,
  output logic                   serial_clock_line_oe_n,
  input  wire logic              serial_data_line_in,
  output logic                   serial_data_line_out,
  output logic                   serial_data_line_oe_n
);

  function automatic logic [CNT_W-1:0] phase_len(input logic [DIV_W-1:0] d,
                                                 input logic [CK_W-1:0]  k);
    return (CNT_W'(d) << k) + PHASE_EXTRA;
  endfunction

  function automatic logic [7:0] sub_byte(input logic [SUB_W-1:0]  s,
                                          input logic [SUBN_W-1:0] k);
    case (k)
      2'h3:    return s[23:16];
      2'h2:    return s[15:8];
      default: return s[7:0];
    endcase
  endfunction

  logic             rst_core_n;
  logic             rst_link_n;
  logic [2:0]       core_in_s;
  logic [4:0]       link_in_s;
  logic             rx_s;
  logic             done_s;
  logic             txa_s;
  logic             go_s;
  logic             stop_s;
  logic             txv_s;
  logic             scl_s;
  logic             sda_s;
  core_st_t         c_r;
  core_st_t         c_nxt;
  link_st_t         l_r;
  link_st_t         l_nxt;
  logic [CNT_W-1:0] lo_len;
  logic [CNT_W-1:0] hi_len;
  logic             stop_pend;
  logic             rx_ev;
  logic             done_ev;
  logic             take;

  bit_sync #(.W(1)) u_rst_core (.clk(core_clk), .rst_n(arst_n), .d(1'b1), .q(rst_core_n));
  bit_sync #(.W(1)) u_rst_link (.clk(link_clk), .rst_n(arst_n), .d(1'b1), .q(rst_link_n));

  // Toggles from the link side and pins all pass two flops
  bit_sync #(.W(3)) u_core_in (
    .clk   (core_clk),
    .rst_n (rst_core_n),
    .d     ({l_r.rx_tgl, l_r.done_tgl, l_r.tx_ack}),
    .q     (core_in_s)
  );
  bit_sync #(.W(5)) u_link_in (
    .clk   (link_clk),
    .rst_n (rst_link_n),
    .d     ({c_r.go_tgl, c_r.stop_tgl, c_r.tx_tgl, serial_clock_line_in, serial_data_line_in}),
    .q     (link_in_s)
  );
  assign {rx_s, done_s, txa_s}              = core_in_s;
  assign {go_s, stop_s, txv_s, scl_s, sda_s} = link_in_s;

  // Core side: configuration capture, holding registers, flags
  always_comb
  begin
    rx_ev       = (rx_s != c_r.rx_seen);
    done_ev     = (done_s != c_r.done_seen);
    take        = start_cmd & master_enable_cmd & ~c_r.busy; // see R14
    c_nxt       = c_r;
    c_nxt.rx_seen   = rx_s;
    c_nxt.done_seen = done_s;
    // Link word is stable for a whole byte time after its toggle
    if (rx_ev)
      c_nxt.rx_data = l_r.rx_word;
    c_nxt.rx_ready = rx_ev | (c_r.rx_ready & ~rx_read); // see R17
    if (take)
    begin
      c_nxt.addr   = slave_address; // see R15
      c_nxt.subn   = subaddress_byte_count;
      c_nxt.sub    = slave_subaddress_value;
      c_nxt.rd     = read_direction_bit;
      c_nxt.nb     = stop_cmd ? ONE_BYTE : data_byte_count; // see R16
      c_nxt.lo_div = low_period_divider; // see R13
      c_nxt.hi_div = high_period_divider;
      c_nxt.ck     = common_clock_divider;
      c_nxt.go_tgl = ~c_r.go_tgl;
      c_nxt.busy   = 1'b1;
      c_nxt.done   = 1'b0;
      c_nxt.nack   = 1'b0;
    end
    else if (stop_cmd & c_r.busy)
      c_nxt.stop_tgl = ~c_r.stop_tgl;
    if (done_ev)
    begin
      c_nxt.busy = 1'b0;
      c_nxt.done = 1'b1; // see R18
      c_nxt.nack = l_r.nack;
    end
    if (tx_load & c_r.tx_empty)
    begin
      c_nxt.tx_word = tx_data;
      c_nxt.tx_tgl  = ~c_r.tx_tgl;
    end
    c_nxt.tx_empty = (c_nxt.tx_tgl == txa_s);
  end

  always_ff @(posedge core_clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
      c_r <= CORE_RST;
    else
      c_r <= c_nxt;
  end

  // Link side: bit engine; config words are held while busy
  always_comb
  begin
    lo_len    = phase_len(c_r.lo_div, c_r.ck); // see R13
    hi_len    = phase_len(c_r.hi_div, c_r.ck);
    stop_pend = (stop_s != l_r.stop_seen);
    l_nxt     = l_r;
    case (l_r.st)
      L_IDLE:
        if (go_s != l_r.go_seen)
        begin
          l_nxt.go_seen   = go_s;
          l_nxt.stop_seen = stop_s;
          l_nxt.st        = L_START; // see R5
          l_nxt.cnt       = hi_len;
          l_nxt.nack      = 1'b0;
          l_nxt.rdph      = c_r.rd & (c_r.subn == '0);
          l_nxt.sub_left  = c_r.subn;
          l_nxt.left      = c_r.nb;
          l_nxt.open      = (c_r.nb == '0); // see R4
        end
      L_START:
        if (scl_s)
        begin
          if (l_r.cnt == '0)
          begin
            l_nxt.st  = L_HOLD;
            l_nxt.cnt = hi_len;
          end
          else
            l_nxt.cnt = l_r.cnt - 16'h0001;
        end
      L_HOLD:
        if (l_r.cnt == '0)
        begin
          l_nxt.st      = L_BLOW;
          l_nxt.cnt     = lo_len;
          l_nxt.bitn    = '0;
          l_nxt.shift   = {c_r.addr, l_r.rdph}; // see R8
          l_nxt.txb     = 1'b1;
          l_nxt.is_addr = 1'b1;
          l_nxt.is_data = 1'b0;
        end
        else
          l_nxt.cnt = l_r.cnt - 16'h0001;
      L_BLOW:
        if (l_r.wait_tx)
        begin
          // Clock held low until software supplies the next byte
          if (txv_s != l_r.tx_ack)
          begin
            l_nxt.shift   = c_r.tx_word;
            l_nxt.tx_ack  = ~l_r.tx_ack;
            l_nxt.wait_tx = 1'b0;
          end
        end
        else if (l_r.cnt == '0)
        begin
          l_nxt.st  = L_BHIGH;
          l_nxt.cnt = hi_len;
        end
        else
          l_nxt.cnt = l_r.cnt - 16'h0001;
      L_BHIGH:
        if (scl_s) // see R25
        begin
          if (l_r.cnt != '0)
            l_nxt.cnt = l_r.cnt - 16'h0001;
          else if (l_r.bitn != ACK_SLOT)
          begin
            l_nxt.shift = {l_r.shift[6:0], sda_s}; // see R2
            l_nxt.bitn  = l_r.bitn + 4'h1; // see R1
            l_nxt.st    = L_BLOW;
            l_nxt.cnt   = lo_len;
            if (!l_r.txb && l_r.open && stop_pend && l_r.bitn == LAST_DATA)
              l_nxt.last = 1'b1;
          end
          else
          begin
            l_nxt.bitn    = '0;
            l_nxt.st      = L_BLOW;
            l_nxt.cnt     = lo_len;
            l_nxt.is_addr = 1'b0;
            if (l_r.txb && sda_s) // see R3
            begin
              l_nxt.nack = 1'b1;
              l_nxt.st   = L_SLOW;
            end
            else if (!l_r.txb)
            begin
              l_nxt.rx_word = l_r.shift;
              l_nxt.rx_tgl  = ~l_r.rx_tgl;
              if (!l_r.open)
                l_nxt.left = l_r.left - ONE_BYTE;
              if (l_r.last)
                l_nxt.st = L_SLOW;
              l_nxt.last = ~l_r.open & (l_r.left == TWO_BYTES); // see R23
            end
            else if (l_r.is_data)
            begin
              if (!l_r.open)
                l_nxt.left = l_r.left - ONE_BYTE;
              if (l_r.open ? stop_pend : (l_r.left == ONE_BYTE))
                l_nxt.st = L_SLOW;
              else
                l_nxt.wait_tx = 1'b1; // see R9
            end
            else if (l_r.sub_left != '0)
            begin
              l_nxt.shift    = sub_byte(c_r.sub, l_r.sub_left); // see R10 R19
              l_nxt.sub_left = l_r.sub_left - 2'h1;
            end
            else if (l_r.rdph)
            begin
              l_nxt.txb     = 1'b0;
              l_nxt.is_data = 1'b1;
              l_nxt.last    = l_r.open ? stop_pend : (l_r.left == ONE_BYTE);
            end
            else if (c_r.rd)
            begin
              l_nxt.rdph = 1'b1; // see R11
              l_nxt.st   = L_PREP; // see R12 R24
            end
            else
            begin
              l_nxt.is_data = 1'b1;
              l_nxt.wait_tx = 1'b1;
            end
          end
        end
      L_PREP:
        if (l_r.cnt == '0)
        begin
          l_nxt.st  = L_START;
          l_nxt.cnt = hi_len;
        end
        else
          l_nxt.cnt = l_r.cnt - 16'h0001;
      L_SLOW:
        if (l_r.cnt == '0)
        begin
          l_nxt.st  = L_SHIGH;
          l_nxt.cnt = hi_len;
        end
        else
          l_nxt.cnt = l_r.cnt - 16'h0001;
      L_SHIGH:
        if (scl_s)
        begin
          if (l_r.cnt == '0)
          begin
            l_nxt.st        = L_IDLE; // see R7
            l_nxt.done_tgl  = ~l_r.done_tgl;
            l_nxt.stop_seen = stop_s;
            l_nxt.wait_tx   = 1'b0;
          end
          else
            l_nxt.cnt = l_r.cnt - 16'h0001;
        end
      default:
        l_nxt = LINK_RST;
    endcase
    // Pins follow the next state so they leave a flop directly
    l_nxt.scl_out  = 1'b0;
    l_nxt.sda_out  = 1'b0;
    l_nxt.scl_oe_n = ~(l_nxt.st inside {L_BLOW, L_PREP, L_SLOW});
    case (l_nxt.st)
      L_HOLD, L_SLOW, L_SHIGH:
        l_nxt.sda_oe_n = 1'b0; // see R6
      L_BLOW, L_BHIGH:
        if (l_nxt.bitn == ACK_SLOT)
          l_nxt.sda_oe_n = l_nxt.txb | l_nxt.last; // see R3 R23
        else
          l_nxt.sda_oe_n = ~l_nxt.txb | l_nxt.shift[7]; // see R2
      default:
        l_nxt.sda_oe_n = 1'b1;
    endcase
  end

  always_ff @(posedge link_clk or negedge rst_link_n)
  begin
    if (!rst_link_n)
      l_r <= LINK_RST;
    else
      l_r <= l_nxt;
  end

  assign tx_empty_flag          = c_r.tx_empty;
  assign rx_data                = c_r.rx_data;
  assign receive_ready_flag     = c_r.rx_ready;
  assign transfer_complete_flag = c_r.done;
  assign nack_flag              = c_r.nack;
  assign busy_flag              = c_r.busy;
  assign serial_clock_line_out  = l_r.scl_out;
  assign serial_clock_line_oe_n = l_r.scl_oe_n;
  assign serial_data_line_out   = l_r.sda_out;
  assign serial_data_line_oe_n  = l_r.sda_oe_n;

  sequence s_data_fall_clk_high;
    $fell(l_r.sda_oe_n) && l_r.scl_oe_n;
  endsequence
  sequence s_data_rise_clk_high;
    $rose(l_r.sda_oe_n) && l_r.scl_oe_n && $past(l_r.scl_oe_n);
  endsequence

  chk_start_cond: assert property (@(posedge link_clk) disable iff (!rst_link_n) // see R6
    s_data_fall_clk_high |-> l_r.st == L_HOLD) else $error("data fell with clock high outside start");
  chk_stop_cond: assert property (@(posedge link_clk) disable iff (!rst_link_n) // see R7
    s_data_rise_clk_high |-> l_r.st == L_IDLE && $past(l_r.st) == L_SHIGH) else $error("bad stop");
  chk_byte_len: assert property (@(posedge link_clk) disable iff (!rst_link_n) // see R1
    l_r.st == L_BHIGH && $past(l_r.st) == L_BLOW |-> l_r.bitn <= ACK_SLOT) else $error("bit count");
  chk_msb_first: assert property (@(posedge link_clk) disable iff (!rst_link_n) // see R2
    l_r.st == L_BHIGH && l_r.txb && l_r.bitn != ACK_SLOT |-> l_r.sda_oe_n == l_r.shift[7])
    else $error("transmit bit not msb of shifter");
  chk_ack_release: assert property (@(posedge link_clk) disable iff (!rst_link_n) // see R3
    l_r.st == L_BHIGH && l_r.txb && l_r.bitn == ACK_SLOT |-> l_r.sda_oe_n)
    else $error("data driven during slave acknowledge");
  chk_rx_nack: assert property (@(posedge link_clk) disable iff (!rst_link_n) // see R23
    l_r.st == L_BHIGH && !l_r.txb && l_r.bitn == ACK_SLOT |-> l_r.sda_oe_n == l_r.last)
    else $error("wrong acknowledge after received byte");
  chk_rstart_read: assert property (@(posedge link_clk) disable iff (!rst_link_n) // see R24
    l_r.st == L_PREP |-> c_r.rd && l_r.rdph) else $error("repeated start in a write");
  chk_stretch_wait: assert property (@(posedge link_clk) disable iff (!rst_link_n) // see R25
    l_r.st == L_BHIGH && !scl_s |=> l_r.st == L_BHIGH && l_r.cnt == $past(l_r.cnt))
    else $error("high phase advanced while clock held low");
  chk_rx_flag: assert property (@(posedge core_clk) disable iff (!rst_core_n) // see R17
    rx_s != c_r.rx_seen |=> receive_ready_flag && rx_data == $past(l_r.rx_word))
    else $error("received byte not flagged");
  chk_done_flag: assert property (@(posedge core_clk) disable iff (!rst_core_n) // see R18
    done_s != c_r.done_seen |=> transfer_complete_flag && !busy_flag) else $error("no complete");

endmodule // two_wire_master

// file: hdl/two_wire_master_pkg.sv
// Constants, states and state records of the two-wire master
package two_wire_master_pkg;

  localparam int ADDR_W = 7;
  localparam int DIV_W  = 8;
  localparam int CK_W   = 3;
  localparam int SUB_W  = 24;
  localparam int SUBN_W = 2;
  localparam int NB_W   = 8;
  localparam int CNT_W  = 16;

  localparam logic [3:0]       ACK_SLOT    = 4'h8;
  localparam logic [3:0]       LAST_DATA   = 4'h7;
  localparam logic [CNT_W-1:0] PHASE_EXTRA = 16'h0004;
  localparam logic [NB_W-1:0]  ONE_BYTE    = 8'h01;
  localparam logic [NB_W-1:0]  TWO_BYTES   = 8'h02;

  typedef enum logic [7:0] {
    L_IDLE  = 8'h01,
    L_START = 8'h02,
    L_HOLD  = 8'h04,
    L_BLOW  = 8'h08,
    L_BHIGH = 8'h10,
    L_PREP  = 8'h20,
    L_SLOW  = 8'h40,
    L_SHIGH = 8'h80
  } link_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [SUBN_W-1:0] subn;
    logic [SUB_W-1:0]  sub;
    logic              rd;
    logic [NB_W-1:0]   nb;
    logic [DIV_W-1:0]  lo_div;
    logic [DIV_W-1:0]  hi_div;
    logic [CK_W-1:0]   ck;
    logic              go_tgl;
    logic              stop_tgl;
    logic              tx_tgl;
    logic [7:0]        tx_word;
    logic              rx_seen;
    logic              done_seen;
    logic [7:0]        rx_data;
    logic              rx_ready;
    logic              done;
    logic              nack;
    logic              tx_empty;
    logic              busy;
  } core_st_t;

  typedef struct packed {
    link_state_t       st;
    logic [CNT_W-1:0]  cnt;
    logic [3:0]        bitn;
    logic [7:0]        shift;
    logic              txb;
    logic              is_addr;
    logic              is_data;
    logic              wait_tx;
    logic              rdph;
    logic              last;
    logic              open;
    logic [SUBN_W-1:0] sub_left;
    logic [NB_W-1:0]   left;
    logic [7:0]        rx_word;
    logic              go_seen;
    logic              stop_seen;
    logic              rx_tgl;
    logic              tx_ack;
    logic              done_tgl;
    logic              nack;
    logic              scl_out;
    logic              scl_oe_n;
    logic              sda_out;
    logic              sda_oe_n;
  } link_st_t;

  localparam core_st_t CORE_RST = '{tx_empty: 1'b1, default: '0};
  localparam link_st_t LINK_RST = '{st: L_IDLE, scl_oe_n: 1'b1, sda_oe_n: 1'b1, default: '0};

endpackage

// file: sim/sensor_slave_model.sv
// Behavioural temperature sensor slave on the two-wire bus
`timescale 1ns/1ns
module sensor_slave_model #(
  parameter logic [2:0]  STRAP     = 3'h7,
  parameter logic [15:0] TEMP_INIT = 16'h1A80
) (
  // Bus wires
  input  wire logic scl_w,
  input  wire logic sda_w,
  output logic      scl_oe_n = 1'b1,
  output logic      sda_oe_n = 1'b1,
  // Test control
  input  wire logic stretch
);
  logic [15:0] regs [4] = '{TEMP_INIT & 16'hFF80, 16'h0000, 16'h4B00, 16'h5000};
  logic [7:0]  ptr = 8'h00;
  logic [7:0]  sh = 8'h00;
  logic [7:0]  txb = 8'h00;
  logic [3:0]  s = 4'h0;
  logic [1:0]  ph = 2'h0;
  logic        seen = 1'b0;
  logic        first = 1'b0;
  logic        hi = 1'b1;

  task automatic take_byte();
    if (ph == 2'h1)
    begin
      ph = 2'h0;
      if (sh[7:1] == {4'h9, STRAP})
      begin
        sda_oe_n = 1'b0;
        ph = sh[0] ? 2'h3 : 2'h2;
        first = 1'b1;
        hi = 1'b1;
      end
    end
    else
    begin
      sda_oe_n = 1'b0;
      if (first)
        ptr = sh;
      else if (ptr[1:0] != 2'h0)
      begin
        if (hi)
          regs[ptr[1:0]][15:8] = sh;
        else
          regs[ptr[1:0]][7:0] = sh;
        hi = !hi;
      end
      first = 1'b0;
    end
  endtask

  // Start and stop detection
  always @(negedge sda_w)
    if (scl_w)
    begin
      ph = 2'h1;
      s = 4'h0;
      seen = 1'b0;
    end
  always @(posedge sda_w)
    if (scl_w)
      ph = 2'h0;

  always @(posedge scl_w)
    if (ph != 2'h0)
    begin
      seen = 1'b1;
      if (s < 4'h8)
        sh = {sh[6:0], sda_w};
      else if (ph == 2'h3 && sda_w)
        ph = 2'h0;
    end

  // Data only changes while the clock is low
  always @(negedge scl_w)
    if (ph != 2'h0 && seen)
    begin
      seen = 1'b0;
      s = (s == 4'h8) ? 4'h0 : s + 4'h1;
      sda_oe_n = 1'b1;
      if (s == 4'h8 && ph != 2'h3)
        take_byte();
      else if (ph == 2'h3 && s != 4'h8)
      begin
        if (s == 4'h0)
        begin
          txb = hi ? regs[ptr[1:0]][15:8] : regs[ptr[1:0]][7:0];
          hi = !hi;
        end
        sda_oe_n = txb[3'h7 - s[2:0]];
      end
      if (s == 4'h0 && stretch)
      begin
        scl_oe_n = 1'b0;
        #3000;
        scl_oe_n = 1'b1;
      end
    end
endmodule // sensor_slave_model

// file: sim/two_wire_master_test.sv
// Self-checking bench for the two-wire master against a sensor model
`timescale 1ns/1ns
module two_wire_master_test;
  import two_wire_master_pkg::*;
  localparam logic [6:0]  SENS = {4'h9, 3'h7};
  localparam logic [15:0] TEMP = 16'h1A80;

  logic        core_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        arst_n = 1'b1;
  logic        en = 1'b0, start = 1'b0, stop = 1'b0, rd = 1'b0;
  logic        tx_load = 1'b0, rx_read = 1'b0, stretch = 1'b0, first = 1'b0;
  logic [6:0]  addr = 7'h00;
  logic [1:0]  subn = 2'h0;
  logic [23:0] sub = 24'h000000;
  logic [7:0]  nb = 8'h00, tx_data = 8'h00, rx_data, fb, acks;
  logic        tx_empty, rx_rdy, done, nack, busy;
  logic        m_scl_out, m_scl_oe_n, m_sda_out, m_sda_oe_n, s_scl_oe_n, s_sda_oe_n;
  wire logic   scl_w, sda_w;
  int          err_count = 0, n_checks = 0, n_st, n_sp, n_ck, k;
  logic [7:0]  txq [$], rxq [$];

  initial
    forever #4 core_clk = ~core_clk;
  initial
  begin
    #37;
    forever #80 link_clk = ~link_clk;
  end

  // Pull-ups; data lags the clock to give slaves some hold
  assign scl_w = (m_scl_oe_n ? 1'b1 : m_scl_out) & s_scl_oe_n;
  assign #20 sda_w = (m_sda_oe_n ? 1'b1 : m_sda_out) & s_sda_oe_n;

  two_wire_master two_wire_master_i (
    .core_clk(core_clk), .arst_n(arst_n), .link_clk(link_clk),
    .master_enable_cmd(en), .start_cmd(start), .stop_cmd(stop),
    .slave_address(addr), .subaddress_byte_count(subn), .read_direction_bit(rd),
    .slave_subaddress_value(sub), .data_byte_count(nb),
    .low_period_divider(8'h01), .high_period_divider(8'h01),
    .common_clock_divider(3'h0),
    .tx_data(tx_data), .tx_load(tx_load), .tx_empty_flag(tx_empty),
    .rx_read(rx_read), .rx_data(rx_data), .receive_ready_flag(rx_rdy),
    .transfer_complete_flag(done), .nack_flag(nack), .busy_flag(busy),
    .serial_clock_line_in(scl_w), .serial_clock_line_out(m_scl_out),
    .serial_clock_line_oe_n(m_scl_oe_n), .serial_data_line_in(sda_w),
    .serial_data_line_out(m_sda_out), .serial_data_line_oe_n(m_sda_oe_n));

  sensor_slave_model #(.STRAP(3'h7), .TEMP_INIT(TEMP)) sensor_slave_model_i (
    .scl_w(scl_w), .sda_w(sda_w), .scl_oe_n(s_scl_oe_n), .sda_oe_n(s_sda_oe_n),
    .stretch(stretch));

  // Wire monitor: conditions, clock pulses, first byte and ack slots
  always @(negedge sda_w)
    if (scl_w)
    begin
      n_st++;
      k = 0;
      first = 1'b1;
    end
  always @(posedge sda_w)
    if (scl_w)
      n_sp++;
  always @(posedge scl_w)
  begin
    n_ck++;
    k++;
    if (k < 9 && first)
      fb = {fb[6:0], sda_w};
    if (k == 9)
    begin
      acks = {acks[6:0], sda_w};
      k = 0;
      first = 1'b0;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic xfer(input logic [6:0] a, input logic [1:0] sn, input logic [23:0] sv,
                      input logic r, input logic [7:0] n, input logic ss);
    int w;
    n_st = 0;
    n_sp = 0;
    n_ck = 0;
    rxq.delete();
    @(negedge core_clk);
    {addr, subn, sub, rd, nb, start, stop} = {a, sn, sv, r, n, 1'b1, ss};
    @(negedge core_clk);
    {start, stop} = 2'b00;
    check(busy, 1'b1);
    for (int i = 0; i < (ss ? 1 : int'(n)); i++)
    begin
      for (w = 0; w < 40000 && (r ? rx_rdy : tx_empty) !== 1'b1; w++)
        @(negedge core_clk);
      if (r)
        rxq.push_back(rx_data);
      else
        tx_data = txq[i];
      {rx_read, tx_load} = {r, !r};
      @(negedge core_clk);
      {rx_read, tx_load} = 2'b00;
      @(negedge core_clk);
    end
    for (w = 0; w < 60000 && done !== 1'b1; w++)
      @(negedge core_clk);
    check(busy, 1'b0);
    check(n_sp, 1);
  endtask

  // Start with enable low must leave the bus and holding register alone
  task automatic refused_start();
    n_st = 0;
    @(negedge core_clk);
    {addr, rd, nb, start} = {SENS, 1'b0, 8'h01, 1'b1};
    @(negedge core_clk);
    start = 1'b0;
    repeat (400) @(negedge core_clk);
    check(busy, 1'b0);
    check(n_st, 0);
    check(done, 1'b0);
    check(tx_empty, 1'b1);
    en = 1'b1;
  endtask

  task automatic write_sub_seq();
    txq = '{8'hA5, 8'h3C, 8'h5A};
    xfer(SENS, 2'h1, 24'h000002, 1'b0, 8'h03, 1'b0);
    check(sensor_slave_model_i.regs[2], 16'h5A3C);
    check(n_st, 1);
    check(n_ck, 46);
    check(fb, {SENS, 1'b0});
    check(acks[4:0], 5'h00);
    check(nack, 1'b0);
  endtask

  task automatic read_sub_seq();
    xfer(SENS, 2'h1, 24'h000006, 1'b1, 8'h02, 1'b0);
    check({rxq[0], rxq[1]}, 16'h5A3C);
    check(n_st, 2);
    check(n_ck, 47);
    check(fb, {SENS, 1'b1});
    check(acks[4:0], 5'h01);
  endtask

  task automatic single_read();
    xfer(SENS, 2'h1, 24'h000000, 1'b1, 8'h05, 1'b1);
    check(rxq.size(), 1);
    check(rxq[0], TEMP[15:8]);
    check(n_st, 2);
    check(n_ck, 38);
    check(acks[3:0], 4'h1);
  endtask

  task automatic read_stretch();
    stretch = 1'b1;
    xfer(SENS, 2'h0, 24'h000000, 1'b1, 8'h02, 1'b0);
    stretch = 1'b0;
    check({rxq[0], rxq[1]}, TEMP & 16'hFF80);
    check(n_st, 1);
    check(n_ck, 28);
    check(acks[2:0], 3'h1);
  endtask

  task automatic wrong_address();
    txq = '{8'h77};
    xfer(7'h20, 2'h0, 24'h000000, 1'b0, 8'h01, 1'b0);
    check(nack, 1'b1);
    check(n_ck, 10);
  endtask

  initial
  begin
    // A real falling edge so both domains see the asynchronous reset
    #1;
    arst_n = 1'b0;
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (100) @(negedge core_clk);
    check({done, tx_empty, rx_rdy}, 3'b010);
    refused_start();
    write_sub_seq();
    read_sub_seq();
    single_read();
    read_stretch();
    wrong_address();
    print_verdict();
  end

  // Whole run takes about 0.4 milliseconds
  initial
  begin
    #750000;
    err_count++;
    print_verdict();
  end
endmodule // two_wire_master_test
